//--- src/hrtl_lighting.sv
// hourly rgb tube lighting: menu, per-hour colour store, pwm and cycling
// assumes buttons and hour are synchronous to sys_clk_i and debounced;
// assumes an external non-volatile store replays settings on nv load
`timescale 1ns/10ps
// Operation
// - long daylight button hold opens menu, zeros
// - twenty-four hourly settings, hours 0 to 23
// - blue, green, red levels 0 to 8
// - alarm, adjust, set buttons change levels
// - daylight press stores hour, advances
// - menu shows edited colour live
// - normal mode shows current hour's colour
// - red nine enables colour cycling
// - green selects cycling speed 0 to 9
// - blue ignored while cycling
// - no cycling during menu editing
// - every stored setting written to nv store
module hrtl_lighting #(
   parameter int HOLD_CYC = hrtl_pkg::HOLD_CYC,  // daylight hold length
   parameter int PWM_DIV  = hrtl_pkg::PWM_DIV,   // clocks per pwm slot
   parameter int CYC_BASE = hrtl_pkg::CYC_BASE   // slowest wheel step
) (
   // clock and reset
   input  wire logic                sys_clk_i,
   input  wire logic                rst_i,
   // push buttons, high while pressed
   input  wire logic                daylight_saving_button_i,
   input  wire logic                alarm_button_i,
   input  wire logic                adjust_button_i,
   input  wire logic                set_button_i,
   // time of day from the timekeeping core
   input  wire logic [4:0]          hour_i,
   // non-volatile store replay
   input  wire logic                nv_ld_valid_i,
   input  wire logic [4:0]          nv_ld_addr_i,
   input  wire hrtl_pkg::hrtl_lvl_s nv_ld_data_i,
   // non-volatile store write
   output logic                     nv_wr_o,
   output logic [4:0]               nv_addr_o,
   output hrtl_pkg::hrtl_lvl_s      nv_data_o,
   // avalon-mm slave
   input  wire logic [3:0]          avs_address_i,
   input  wire logic                avs_read_i,
   input  wire logic                avs_write_i,
   input  wire logic [3:0]          avs_byteenable_i,
   input  wire logic [31:0]         avs_writedata_i,
   output logic [31:0]              avs_readdata_o,
   output logic                     avs_waitrequest_o,
   // led drive and menu status
   output hrtl_pkg::hrtl_led_s      led_o,
   output logic                     menu_active_o,
   output logic [4:0]               edit_hour_o
);
   // =========================================================
   // control state
   hrtl_pkg::hrtl_mode_e mode_r, mode_nxt;       // normal or menu
   logic [25:0]         hold_r, hold_nxt;        // daylight hold counter
   logic                armed_r, armed_nxt;      // daylight released in menu
   logic [4:0]          ehour_r, ehour_nxt;      // hour under edit
   hrtl_pkg::hrtl_lvl_s edit_r, edit_nxt;        // levels under edit
   hrtl_pkg::hrtl_lvl_s mem_r [hrtl_pkg::HOURS]; // per-hour settings
   hrtl_pkg::hrtl_lvl_s mem_nxt [hrtl_pkg::HOURS];
   logic [3:0]          btn_q;                   // previous buttons
   logic                nv_wr_nxt;
   logic [4:0]          nv_addr_nxt;
   hrtl_pkg::hrtl_lvl_s nv_data_nxt;
   logic [4:0]          sel_r, sel_nxt;          // bus hour select
   logic                wait_r, wait_nxt;        // waitrequest
   logic [31:0]         rdata_r, rdata_nxt;      // read data
   // =========================================================
   // led state
   logic [15:0]         pdiv_r, pdiv_nxt;        // pwm slot divider
   logic [2:0]          pwm_r, pwm_nxt;          // pwm slot 0..7
   logic [23:0]         cdiv_r, cdiv_nxt;        // wheel step divider
   logic [4:0]          phase_r, phase_nxt;      // wheel position
   hrtl_pkg::hrtl_led_s led_nxt;
   // shared combinational views
   hrtl_pkg::hrtl_lvl_s cfg;                     // colour source now
   logic                cycling;                 // wheel running
   logic [3:0]          btn_now;
   logic [3:0]          rise;                    // button press pulses
   logic                bus_take;                // request accepted

   assign btn_now = {daylight_saving_button_i, alarm_button_i,
                     adjust_button_i, set_button_i};
   assign rise    = btn_now & ~btn_q;
   assign bus_take = (avs_read_i | avs_write_i) & wait_r;

   // =========================================================
   // colour source select
   always_comb begin
      if (mode_r == hrtl_pkg::MODE_MENU) begin
         cfg = edit_r;
      end else if (hour_i <= hrtl_pkg::HOUR_LAST) begin
         cfg = mem_r[hour_i];
      end else begin
         cfg = hrtl_pkg::LVL_RST;
      end
      cycling = (mode_r == hrtl_pkg::MODE_NORMAL) &&
                (cfg.red == hrtl_pkg::LVL_CYCLE);
   end

   // =========================================================
   // menu, storage and bus next state
   always_comb begin
      mode_nxt    = mode_r;
      hold_nxt    = hold_r;
      armed_nxt   = armed_r;
      ehour_nxt   = ehour_r;
      edit_nxt    = edit_r;
      mem_nxt     = mem_r;
      nv_wr_nxt   = 1'b0;
      nv_addr_nxt = nv_addr_o;
      nv_data_nxt = nv_data_o;
      sel_nxt     = sel_r;
      wait_nxt    = ~bus_take;
      rdata_nxt   = rdata_r;
      // hold counter saturates at the entry point, HOLD_CYC - 1
      if (!daylight_saving_button_i) begin
         hold_nxt = '0;
      end else if (hold_r < 26'(HOLD_CYC - 1)) begin
         hold_nxt = hold_r + 26'h1;
      end
      case (mode_r)
         hrtl_pkg::MODE_NORMAL: begin
            if (daylight_saving_button_i && hold_r == 26'(HOLD_CYC - 1)) begin
               mode_nxt  = hrtl_pkg::MODE_MENU;
               ehour_nxt = 5'h00;
               edit_nxt  = hrtl_pkg::LVL_RST;
               armed_nxt = 1'b0;
            end
         end
         hrtl_pkg::MODE_MENU: begin
            // the entry hold must end before a daylight press counts
            if (!daylight_saving_button_i) begin
               armed_nxt = 1'b1;
            end
            if (rise[2]) begin
               edit_nxt.blue = (edit_r.blue >= hrtl_pkg::LVL_MAX) ? 4'h0
                               : edit_r.blue + 4'h1;
            end
            // green reaches 9 only as a speed
            if (rise[1]) begin
               if (edit_r.red == hrtl_pkg::LVL_CYCLE) begin
                  edit_nxt.green = (edit_r.green >= hrtl_pkg::SPEED_MAX) ? 4'h0
                                   : edit_r.green + 4'h1;
               end else begin
                  edit_nxt.green = (edit_r.green >= hrtl_pkg::LVL_MAX) ? 4'h0
                                   : edit_r.green + 4'h1;
               end
            end
            // set steps red up to the cycle code
            if (rise[0]) begin
               if (edit_r.red >= hrtl_pkg::LVL_CYCLE) begin
                  edit_nxt.red = 4'h0;
                  // a speed of 9 is no brightness once cycling ends
                  if (edit_r.green > hrtl_pkg::LVL_MAX) begin
                     edit_nxt.green = hrtl_pkg::LVL_MAX;
                  end
               end else begin
                  edit_nxt.red = edit_r.red + 4'h1;
               end
            end
            if (rise[3] && armed_r) begin
               mem_nxt[ehour_r] = edit_r;
               // nv write of the stored hour
               nv_wr_nxt   = 1'b1;
               nv_addr_nxt = ehour_r;
               nv_data_nxt = edit_r;
               edit_nxt    = hrtl_pkg::LVL_RST;
               hold_nxt    = '0;
               if (ehour_r == hrtl_pkg::HOUR_LAST) begin
                  mode_nxt  = hrtl_pkg::MODE_NORMAL;
                  ehour_nxt = 5'h00;
               end else begin
                  ehour_nxt = ehour_r + 5'h1;
               end
            end
         end
         default: begin
            mode_nxt = hrtl_pkg::MODE_NORMAL;
         end
      endcase
      // writes land at the completing edge, where waitrequest is low
      if (avs_write_i && !wait_r) begin
         if (avs_address_i == hrtl_pkg::REG_SEL && avs_byteenable_i[0]) begin
            sel_nxt = avs_writedata_i[4:0];
         end else if (avs_address_i == hrtl_pkg::REG_SETTING &&
                      avs_byteenable_i[1:0] == 2'b11 &&
                      mode_r == hrtl_pkg::MODE_NORMAL &&
                      sel_r <= hrtl_pkg::HOUR_LAST && !nv_wr_nxt) begin
            mem_nxt[sel_r] = avs_writedata_i[11:0];
            // nv write of a bus store
            nv_wr_nxt   = 1'b1;
            nv_addr_nxt = sel_r;
            nv_data_nxt = avs_writedata_i[11:0];
         end
      end
      // replay from the nv store yields to any store this cycle
      if (nv_ld_valid_i && !nv_wr_nxt && nv_ld_addr_i <= hrtl_pkg::HOUR_LAST) begin
         mem_nxt[nv_ld_addr_i] = nv_ld_data_i;
      end
      // read data, zero for unmapped offsets
      if (bus_take && avs_read_i) begin
         rdata_nxt = 32'h0000_0000;
         case (avs_address_i)
            hrtl_pkg::REG_STATUS: begin
               rdata_nxt[hrtl_pkg::ST_MENU_B] = (mode_r == hrtl_pkg::MODE_MENU);
               rdata_nxt[hrtl_pkg::ST_CYC_B]  = cycling;
               rdata_nxt[hrtl_pkg::ST_EHOUR_LO +: 5] = ehour_r;
               rdata_nxt[hrtl_pkg::ST_HOUR_LO +: 5]  = hour_i;
            end
            hrtl_pkg::REG_SEL: begin
               rdata_nxt[4:0] = sel_r;
            end
            hrtl_pkg::REG_SETTING: begin
               if (sel_r <= hrtl_pkg::HOUR_LAST) begin
                  rdata_nxt[11:0] = mem_r[sel_r];
               end
            end
            default: begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // =========================================================
   // control registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_r            <= hrtl_pkg::MODE_NORMAL;
         hold_r            <= '0;
         armed_r           <= 1'b0;
         ehour_r           <= 5'h00;
         edit_r            <= hrtl_pkg::LVL_RST;
         mem_r             <= '{default: hrtl_pkg::LVL_RST};
         btn_q             <= 4'h0;
         nv_wr_o           <= 1'b0;
         nv_addr_o         <= 5'h00;
         nv_data_o         <= hrtl_pkg::LVL_RST;
         sel_r             <= hrtl_pkg::SEL_RST;
         wait_r            <= 1'b1;
         rdata_r           <= 32'h0000_0000;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= 32'h0000_0000;
         menu_active_o     <= 1'b0;
         edit_hour_o       <= 5'h00;
      end else begin
         mode_r            <= mode_nxt;
         hold_r            <= hold_nxt;
         armed_r           <= armed_nxt;
         ehour_r           <= ehour_nxt;
         edit_r            <= edit_nxt;
         mem_r             <= mem_nxt;
         btn_q             <= btn_now;
         nv_wr_o           <= nv_wr_nxt;
         nv_addr_o         <= nv_addr_nxt;
         nv_data_o         <= nv_data_nxt;
         sel_r             <= sel_nxt;
         wait_r            <= wait_nxt;
         rdata_r           <= rdata_nxt;
         avs_waitrequest_o <= wait_nxt;
         avs_readdata_o    <= rdata_nxt;
         menu_active_o     <= (mode_nxt == hrtl_pkg::MODE_MENU);
         edit_hour_o       <= ehour_nxt;
      end
   end

   // =========================================================
   // pwm slots, colour wheel and led next state
   always_comb begin
      logic [3:0]  r_lvl;
      logic [3:0]  g_lvl;
      logic [3:0]  b_lvl;
      logic [3:0]  k;
      logic [23:0] limit;
      r_lvl     = 4'h0;
      g_lvl     = 4'h0;
      b_lvl     = 4'h0;
      k         = {1'b0, phase_r[2:0]};
      limit     = 24'(CYC_BASE) >> cfg.green;
      pdiv_nxt  = pdiv_r + 16'h1;
      pwm_nxt   = pwm_r;
      cdiv_nxt  = cdiv_r;
      phase_nxt = phase_r;
      // slow rate as one enable pulse per pwm slot
      if (pdiv_r >= 16'(PWM_DIV - 1)) begin
         pdiv_nxt = 16'h0;
         pwm_nxt  = pwm_r + 3'h1;
      end
      if (!cycling) begin
         cdiv_nxt = 24'h0;
      end else if (cdiv_r >= limit - 24'h1) begin
         cdiv_nxt  = 24'h0;
         phase_nxt = (phase_r >= hrtl_pkg::PHASE_LAST) ? 5'h00 : phase_r + 5'h1;
      end else begin
         cdiv_nxt = cdiv_r + 24'h1;
      end
      if (cycling) begin
         case (phase_r[4:3])
            2'b00: begin
               r_lvl = hrtl_pkg::LVL_MAX - k;
               g_lvl = k;
            end
            2'b01: begin
               g_lvl = hrtl_pkg::LVL_MAX - k;
               b_lvl = k;
            end
            default: begin
               b_lvl = hrtl_pkg::LVL_MAX - k;
               r_lvl = k;
            end
         endcase
      end else begin
         r_lvl = (cfg.red > hrtl_pkg::LVL_MAX) ? hrtl_pkg::LVL_MAX : cfg.red;
         g_lvl = (cfg.green > hrtl_pkg::LVL_MAX) ? hrtl_pkg::LVL_MAX : cfg.green;
         b_lvl = (cfg.blue > hrtl_pkg::LVL_MAX) ? hrtl_pkg::LVL_MAX : cfg.blue;
      end
      // level n lights n of 8 slots; 8 is always on
      led_nxt.red   = r_lvl > {1'b0, pwm_r};
      led_nxt.green = g_lvl > {1'b0, pwm_r};
      led_nxt.blue  = b_lvl > {1'b0, pwm_r};
   end

   // =========================================================
   // led registers
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pdiv_r  <= 16'h0;
         pwm_r   <= 3'h0;
         cdiv_r  <= 24'h0;
         phase_r <= 5'h00;
         led_o   <= '{red: 1'b0, green: 1'b0, blue: 1'b0};
      end else begin
         pdiv_r  <= pdiv_nxt;
         pwm_r   <= pwm_nxt;
         cdiv_r  <= cdiv_nxt;
         phase_r <= phase_nxt;
         led_o   <= led_nxt;
      end
   end
endmodule

//--- src/hrtl_pkg.sv
// package for the hourly tube lighting block: constants, types, map
// assumes one 20 MHz clock and an avalon-mm slave with 4-bit byte address
package hrtl_pkg;
   // =========================================================
   // sizes and level codes
   localparam int          HOURS      = 24;       // settings, one per hour
   localparam logic [4:0]  HOUR_LAST  = 5'h17;    // hour twenty-three
   localparam logic [3:0]  LVL_MAX    = 4'h8;     // full brightness
   localparam logic [3:0]  LVL_CYCLE  = 4'h9;     // red code for cycling
   localparam logic [3:0]  SPEED_MAX  = 4'h9;     // fastest cycling speed
   localparam logic [4:0]  PHASE_LAST = 5'h17;    // 24-step colour wheel
   // =========================================================
   // timing
   localparam int          CLK_HZ     = 20_000_000;
   localparam int          HOLD_MS    = 2000;     // menu entry hold
   localparam int          HOLD_CYC   = CLK_HZ / 1000 * HOLD_MS;
   localparam int          PWM_DIV    = 250;      // clocks per pwm slot
   localparam int          CYC_BASE   = 4_000_000; // slowest wheel step
   // =========================================================
   // register map (byte addresses)
   localparam logic [3:0]  REG_STATUS  = 4'h0;
   localparam logic [3:0]  REG_SEL     = 4'h4;
   localparam logic [3:0]  REG_SETTING = 4'h8;
   localparam logic [4:0]  SEL_RST     = 5'h00;
   // status field positions
   localparam int          ST_MENU_B   = 0;
   localparam int          ST_CYC_B    = 1;
   localparam int          ST_EHOUR_LO = 8;
   localparam int          ST_HOUR_LO  = 16;
   // =========================================================
   // types
   typedef struct packed {
      logic [3:0] red;
      logic [3:0] green;
      logic [3:0] blue;
   } hrtl_lvl_s;
   localparam hrtl_lvl_s   LVL_RST = '{red: 4'h0, green: 4'h0, blue: 4'h0};

   typedef struct packed {
      logic       red;
      logic       green;
      logic       blue;
   } hrtl_led_s;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_MENU   = 2'b01
   } hrtl_mode_e;
endpackage

//--- test/hrtl_lighting_assertions.sv
// checker for the hourly tube lighting block, watching top ports only
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/10ps
module hrtl_chk (
   // clock and reset
   input wire logic                sys_clk_i,
   input wire logic                rst_i,
   // user side and time of day
   input wire logic                daylight_saving_button_i,
   input wire logic [4:0]          hour_i,
   // bus handshake
   input wire logic                avs_read_i,
   input wire logic                avs_write_i,
   input wire logic                avs_waitrequest_o,
   // store, leds and menu
   input wire logic                nv_wr_o,
   input wire hrtl_pkg::hrtl_lvl_s nv_data_o,
   input wire hrtl_pkg::hrtl_led_s led_o,
   input wire logic                menu_active_o,
   input wire logic [4:0]          edit_hour_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // bus handshake: taken request answered after exactly one cycle
   property p_ans;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
   endproperty
   a_ans: assert property (p_ans) else $error("request not answered in one cycle");
   property p_one;
      !avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_one: assert property (p_one) else $error("waitrequest low too long");
   property p_idle;
      !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o;
   endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   // ==========================================================
   // menu entry and hour stepping
   property p_open;
      $rose(menu_active_o) |-> $past(daylight_saving_button_i) && edit_hour_o == 5'h00;
   endproperty
   a_open: assert property (p_open) else $error("menu opened wrongly");
   property p_adv;
      menu_active_o && $past(menu_active_o) && $changed(edit_hour_o)
         |-> edit_hour_o == $past(edit_hour_o) + 5'h01;
   endproperty
   a_adv: assert property (p_adv) else $error("edit hour skipped");
   // ==========================================================
   // store pulses last one cycle; those while the menu is active carry legal levels
   property p_nv1;
      nv_wr_o |=> !nv_wr_o;
   endproperty
   a_nv1: assert property (p_nv1) else $error("store pulse too long");
   property p_nvrng;
      nv_wr_o && menu_active_o |-> nv_data_o.blue <= hrtl_pkg::LVL_MAX
         && nv_data_o.red <= hrtl_pkg::LVL_CYCLE && nv_data_o.green <= hrtl_pkg::SPEED_MAX;
   endproperty
   a_nvrng: assert property (p_nvrng) else $error("stored level out of range");
   // an hour outside the day shows dark outside the menu
   property p_dark;
      (hour_i > 5'h17 && !menu_active_o) [*4] |-> led_o == 3'b000;
   endproperty
   a_dark: assert property (p_dark) else $error("leds lit for bad hour");
   // main scenarios
   c_menu: cover property ($rose(menu_active_o));
   c_store: cover property (nv_wr_o && menu_active_o);
   c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule
bind hrtl_lighting hrtl_chk u_hrtl_chk (.sys_clk_i, .rst_i, .daylight_saving_button_i,
   .hour_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .nv_wr_o, .nv_data_o,
   .led_o, .menu_active_o, .edit_hour_o);

//--- test/hrtl_user_panel.sv
// user panel model: four push buttons and an led duty meter
// assumes buttons are sampled on the rising edge of sys_clk_i
`timescale 1ns/10ps
module hrtl_user_panel #(
   parameter int PWM_DIV = 2  // clocks per pwm slot of the block
) (
   // clock
   input  wire logic                sys_clk_i,
   // buttons: [3] daylight, [2] alarm, [1] adjust, [0] set
   output logic [3:0]               btn_o,
   // led drive from the block
   input  wire hrtl_pkg::hrtl_led_s led_i
);
   initial btn_o = 4'h0;
   // one press held for some clocks, then a gap so edges stay distinct
   task automatic press(input int b, input int hold);
      @(posedge sys_clk_i);
      btn_o[b] <= 1'b1;
      repeat (hold) @(posedge sys_clk_i);
      btn_o <= 4'h0;
      repeat (3) @(posedge sys_clk_i);
   endtask
   // on-clocks over whole frames of 8 slots, any phase
   task automatic duty(input int frames, output int r, output int g, output int b);
      r = 0;
      g = 0;
      b = 0;
      repeat (frames * 8 * PWM_DIV) begin
         @(posedge sys_clk_i);
         r += int'(led_i.red);
         g += int'(led_i.green);
         b += int'(led_i.blue);
      end
   endtask
endmodule

//--- test/test_hourly_rgb_tube_lighting.sv
// self-checking bench for the hourly tube lighting block
// assumes short counts: hold 20, pwm slot 2, wheel base 1024
`timescale 1ns/10ps
module test_hourly_rgb_tube_lighting;
   // ==========================================================
   // design signals
   logic                sys_clk_i;
   logic                rst_i;
   logic [3:0]          btn;
   logic [4:0]          hour_i;
   logic                nv_ld_valid_i;
   logic [4:0]          nv_ld_addr_i;
   hrtl_pkg::hrtl_lvl_s nv_ld_data_i;
   logic                nv_wr_o;
   logic [4:0]          nv_addr_o;
   hrtl_pkg::hrtl_lvl_s nv_data_o;
   logic [3:0]          avs_address_i;
   logic                avs_read_i;
   logic                avs_write_i;
   logic [3:0]          avs_byteenable_i;
   logic [31:0]         avs_writedata_i;
   logic [31:0]         avs_readdata_o;
   logic                avs_waitrequest_o;
   hrtl_pkg::hrtl_led_s led_o;
   logic                menu_active_o;
   logic [4:0]          edit_hour_o;
   // bench model and bookkeeping
   logic [11:0]         mdl [24];
   logic [16:0]         nv_q [$];
   logic [31:0]         rd;
   logic [11:0]         v;
   logic [4:0]          h;
   int                  err_total;
   int                  n_checks;
   int                  r_on, g_on, b_on;
   hrtl_lighting #(.HOLD_CYC(20), .PWM_DIV(2), .CYC_BASE(1024)) u_hrtl_lighting (
      .sys_clk_i, .rst_i, .daylight_saving_button_i(btn[3]), .alarm_button_i(btn[2]),
      .adjust_button_i(btn[1]), .set_button_i(btn[0]), .hour_i, .nv_ld_valid_i,
      .nv_ld_addr_i, .nv_ld_data_i, .nv_wr_o, .nv_addr_o, .nv_data_o, .avs_address_i,
      .avs_read_i, .avs_write_i, .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o,
      .avs_waitrequest_o, .led_o, .menu_active_o, .edit_hour_o);
   hrtl_user_panel #(.PWM_DIV(2)) u_hrtl_user_panel (.sys_clk_i, .btn_o(btn), .led_i(led_o));
   initial begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   // every store pulse is queued as {hour, levels}
   always @(posedge sys_clk_i) if (nv_wr_o === 1'b1) nv_q.push_back({nv_addr_o, nv_data_o});
   // ==========================================================
   // checking and closing
   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_byteenable_i <= be;
      avs_write_i <= we;
      avs_read_i <= !we;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20) begin
         err_total++;
         final_report();
      end
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask
   task automatic nvchk(input logic [4:0] hr, input logic [11:0] d);
      repeat (2) @(posedge sys_clk_i);
      chk(32'(nv_q.size()), 32'h1);
      if (nv_q.size() > 0) chk({15'h0, nv_q.pop_front()}, {15'h0, hr, d});
   endtask
   // duty over a frame: level n lights n of 8 slots; red 9 shows as 8
   task automatic ledchk(input logic [11:0] lv);
      int r, g, b, e;
      repeat (20) @(posedge sys_clk_i);
      u_hrtl_user_panel.duty(1, r, g, b);
      e = lv[11:8] > 4'h8 ? 8 : int'(lv[11:8]);
      chk(32'(r * 65536 + g * 256 + b), 32'((e * 65536 + lv[7:4] * 256 + lv[3:0]) * 2));
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rst_i = 1'b1;
      hour_i = 5'h00;
      nv_ld_valid_i = 1'b0;
      nv_ld_addr_i = 5'h00;
      nv_ld_data_i = '0;
      {avs_address_i, avs_read_i, avs_write_i, avs_byteenable_i} = '0;
      avs_writedata_i = 32'h0;
      err_total = 0;
      n_checks = 0;
      foreach (mdl[i]) mdl[i] = 12'h000;
      void'($urandom(32'h72e38c96));
      repeat (12) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk({28'h0, led_o, avs_waitrequest_o}, 32'h1);
      // random settings over the bus, a refused half write, read back
      repeat (3) begin
         h = 5'($urandom_range(23));
         v = {4'($urandom_range(8)), 4'($urandom_range(8)), 4'($urandom_range(8))};
         bus(1'b1, hrtl_pkg::REG_SEL, {27'h0, h}, 4'hF);
         bus(1'b1, hrtl_pkg::REG_SETTING, {20'h0, v}, 4'hF);
         mdl[h] = v;
         nvchk(h, v);
         bus(1'b1, hrtl_pkg::REG_SETTING, 32'hFFF, 4'h1);
         bus(1'b0, hrtl_pkg::REG_SETTING, 32'h0, 4'hF);
         chk(rd, {20'h0, mdl[h]});
      end
      hour_i <= h;
      ledchk(mdl[h]);
      bus(1'b0, 4'hC, 32'h0, 4'hF);
      chk(rd, 32'h0);
      // replay from the store into hour 7
      v = 12'($urandom_range(12'h888)) & 12'h777;
      @(posedge sys_clk_i);
      {nv_ld_valid_i, nv_ld_addr_i, nv_ld_data_i} <= {1'b1, 5'h07, v};
      @(posedge sys_clk_i);
      nv_ld_valid_i <= 1'b0;
      mdl[7] = v;
      bus(1'b1, hrtl_pkg::REG_SEL, 32'h7, 4'hF);
      bus(1'b0, hrtl_pkg::REG_SETTING, 32'h0, 4'hF);
      chk(rd, {20'h0, mdl[7]});
      hour_i <= 5'h19;
      ledchk(12'h000);
      // long hold opens the menu at hour zero, all dark
      hour_i <= 5'h03;
      u_hrtl_user_panel.press(3, 25);
      chk({31'h0, menu_active_o}, 32'h1);
      ledchk(12'h000);
      bus(1'b0, hrtl_pkg::REG_STATUS, 32'h0, 4'hF);
      chk(rd, 32'h00030001);
      bus(1'b1, hrtl_pkg::REG_SETTING, 32'h888, 4'hF);
      bus(1'b0, hrtl_pkg::REG_SETTING, 32'h0, 4'hF);
      chk(rd, {20'h0, mdl[7]});
      // set red to 9, green 2, blue 1, shown live and static
      repeat (9) u_hrtl_user_panel.press(0, 1);
      repeat (2) u_hrtl_user_panel.press(1, 1);
      u_hrtl_user_panel.press(2, 1);
      ledchk(12'h921);
      for (int i = 0; i < 24; i++) begin
         v = (i == 0) ? 12'h921 : (i == 23) ? 12'h001 : 12'h000;
         if (i == 23) repeat (10) u_hrtl_user_panel.press(2, 1);
         u_hrtl_user_panel.press(3, 2);
         mdl[i] = v;
         nvchk(5'(i), v);
         chk({27'h0, edit_hour_o}, (i == 23) ? 32'h0 : 32'(i + 1));
      end
      chk({31'h0, menu_active_o}, 32'h0);
      // red 9 at hour zero cycles in normal mode
      hour_i <= 5'h00;
      repeat (4) @(posedge sys_clk_i);
      bus(1'b0, hrtl_pkg::REG_STATUS, 32'h0, 4'hF);
      chk(rd, 32'h2);
      // speed 2 steps every 256 clocks: one turn is 384 frames, each colour 2048 on
      u_hrtl_user_panel.duty(384, r_on, g_on, b_on);
      chk(32'(r_on), 32'h800);
      chk(32'(g_on), 32'h800);
      chk(32'(b_on), 32'h800);
      hour_i <= 5'h17;
      ledchk(mdl[23]);
      final_report();
   end
endmodule
